// >>> hdl/cci_irq.sv
// Core interrupt detection, masking and non-maskable request logic
`timescale 1ns/1ps

module cci_irq (
   // Clock, reset and freeze
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Interrupt sources
   input wire logic nmi_in_b,
   input wire logic core_master_clock_out,
   input wire logic [4:0] hw_irq_lines,
   input wire logic pipeline_run,
   // Pipeline side
   output logic core_irq,
   output logic nmi_request,
   output logic nmi_redirect,
   output logic [31:0] redirect_vector,
   // Event interrupt
   output logic irq_out
);

   // All state of the block
   typedef struct packed {
      logic nmi_s1;
      logic nmi_s2;
      logic mco_s1;
      logic mco_s2;
      logic mco_prev;
      logic [4:0] line_s1;
      logic [4:0] line_s2;
      logic nmi_lat;
      logic nmi_req;
      logic nmi_served;
      logic redirect;
      logic [31:0] vector;
      logic ie;
      logic exception_level_bit;
      logic [7:0] mask;
      logic [1:0] sw_pend;
      logic [4:0] hw_pend;
      logic tmr_pend;
      logic [4:0] int_reg;
      logic [31:0] count;
      logic [31:0] compare;
      logic core_irq;
      logic [cci_pkg::EV_W-1:0] evt_stat;
      logic [cci_pkg::EV_W-1:0] evt_en;
      logic irq_out;
      logic waitreq;
      logic [31:0] rdata;
   } cci_state_t;

   localparam cci_state_t ST_RST = '{
      nmi_s1: cci_pkg::NMI_PIN_IDLE,
      nmi_s2: cci_pkg::NMI_PIN_IDLE,
      nmi_lat: cci_pkg::NMI_PIN_IDLE,
      waitreq: cci_pkg::WAIT_IDLE,
      mask: cci_pkg::MASK_RST,
      count: cci_pkg::COUNT_RST,
      compare: cci_pkg::COMPARE_RST,
      default: '0
   };

   cci_state_t st_reg;
   cci_state_t st_next;

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // Full cause view: pending bits at 15:8
   function automatic logic [7:0] pend_of(input cci_state_t s);
      return {s.tmr_pend, s.hw_pend, s.sw_pend};
   endfunction : pend_of

   // Combined masked request with enable and exception level
   function automatic logic irq_of(input cci_state_t s);
      return (|(pend_of(s) & s.mask)) & s.ie & ~s.exception_level_bit;
   endfunction : irq_of

   logic bus_req;
   logic wr_go;
   logic rd_first;
   logic tmr_match;
   logic mco_rise;
   logic [31:0] status_view;
   logic [31:0] cause_view;
   logic [31:0] wr_status;
   logic [31:0] wr_cause;
   logic [31:0] wr_intreg;
   logic [31:0] wr_evt_en;

   // Bus request phases: first edge answers, second edge commits the write
   assign bus_req = avs_read | avs_write;
   assign rd_first = bus_req & st_reg.waitreq;
   assign wr_go = avs_write & ~st_reg.waitreq;
   assign tmr_match = st_reg.count == st_reg.compare;
   assign mco_rise = st_reg.mco_s2 & ~st_reg.mco_prev;

   // Register views shared by read and write paths
   always_comb begin
      status_view = 32'h0000_0000;
      status_view[cci_pkg::ST_IE_POS] = st_reg.ie;
      status_view[cci_pkg::ST_EXL_POS] = st_reg.exception_level_bit;
      status_view[cci_pkg::ST_MASK_LSB +: 8] = st_reg.mask;
      cause_view = 32'h0000_0000;
      cause_view[cci_pkg::CA_PEND_LSB +: 8] = pend_of(st_reg);
      wr_status = be_merge(status_view, avs_writedata, avs_byteenable);
      wr_cause = be_merge(cause_view, avs_writedata, avs_byteenable);
      // Narrow registers merge through full-width images, then keep their low bits
      wr_intreg = be_merge({27'h0, st_reg.int_reg}, avs_writedata, avs_byteenable);
      wr_evt_en = be_merge({29'h0, st_reg.evt_en}, avs_writedata, avs_byteenable);
   end

   // Next-state logic; low clock enable freezes everything
   always_comb begin
      st_next = st_reg;
      if (clk_en) begin
         // Two-flop synchronisers for outside inputs
         st_next.nmi_s1 = nmi_in_b;
         st_next.nmi_s2 = st_reg.nmi_s1;
         st_next.mco_s1 = core_master_clock_out;
         st_next.mco_s2 = st_reg.mco_s1;
         st_next.mco_prev = st_reg.mco_s2;
         st_next.line_s1 = hw_irq_lines;
         st_next.line_s2 = st_reg.line_s1;

         // Latch only on master clock out rising edge
         if (mco_rise) begin
            st_next.nmi_lat = st_reg.nmi_s2;
         end
         st_next.nmi_req = ~st_next.nmi_lat;

         // One redirect per request, taken only while running, never masked
         st_next.redirect = 1'b0;
         if (!st_reg.nmi_req) begin
            st_next.nmi_served = 1'b0;
         end else if (pipeline_run && !st_reg.nmi_served) begin
            st_next.redirect = 1'b1;
            st_next.nmi_served = 1'b1;
            st_next.vector = cci_pkg::RESET_VECTOR;
         end

         // Interrupt register ORed with live lines
         st_next.hw_pend = st_reg.int_reg | st_reg.line_s2;

         // Free-running count
         st_next.count = st_reg.count + 32'h0000_0001;

         // Register writes commit on the edge that raises waitrequest again
         if (wr_go) begin
            case (avs_address)
               cci_pkg::OFF_STATUS: begin
                  st_next.ie = wr_status[cci_pkg::ST_IE_POS];
                  st_next.exception_level_bit = wr_status[cci_pkg::ST_EXL_POS];
                  st_next.mask = wr_status[cci_pkg::ST_MASK_LSB +: 8];
               end
               cci_pkg::OFF_CAUSE: begin
                  // Only the software bits are writable
                  st_next.sw_pend = wr_cause[cci_pkg::CA_SW_LSB +: 2];
               end
               cci_pkg::OFF_INTREG: begin
                  st_next.int_reg = wr_intreg[4:0];
               end
               cci_pkg::OFF_COUNT: begin
                  st_next.count = be_merge(st_reg.count, avs_writedata, avs_byteenable);
               end
               cci_pkg::OFF_COMPARE: begin
                  st_next.compare = be_merge(st_reg.compare, avs_writedata, avs_byteenable);
               end
               cci_pkg::OFF_EVT_EN: begin
                  st_next.evt_en = wr_evt_en[cci_pkg::EV_W-1:0];
               end
               default: begin
               end
            endcase
         end

         // Timer pending: compare write clears, a match in the same cycle wins
         if (wr_go && avs_address == cci_pkg::OFF_COMPARE) begin
            st_next.tmr_pend = 1'b0;
         end
         if (tmr_match) begin
            st_next.tmr_pend = 1'b1;
         end

         // AND-OR of pending with mask, then enable and level
         st_next.core_irq = irq_of(st_reg);

         // Sticky events: clear first, then set so a new event is never lost
         if (wr_go && avs_address == cci_pkg::OFF_EVT_CLR) begin
            st_next.evt_stat = st_reg.evt_stat & ~avs_writedata[cci_pkg::EV_W-1:0];
         end
         if (st_next.core_irq && !st_reg.core_irq) begin
            st_next.evt_stat[cci_pkg::EV_CORE_IRQ] = 1'b1;
         end
         if (st_next.redirect) begin
            st_next.evt_stat[cci_pkg::EV_NMI] = 1'b1;
         end
         if (tmr_match) begin
            st_next.evt_stat[cci_pkg::EV_TIMER] = 1'b1;
         end
         st_next.irq_out = |(st_reg.evt_stat & st_reg.evt_en);

         // Bus handshake: one wait cycle, answer with data, then back to wait
         st_next.waitreq = ~rd_first;
         if (rd_first) begin
            case (avs_address)
               cci_pkg::OFF_STATUS: st_next.rdata = status_view;
               cci_pkg::OFF_CAUSE: st_next.rdata = cause_view;
               cci_pkg::OFF_INTREG: st_next.rdata = {27'h0, st_reg.int_reg};
               cci_pkg::OFF_COUNT: st_next.rdata = st_reg.count;
               cci_pkg::OFF_COMPARE: st_next.rdata = st_reg.compare;
               cci_pkg::OFF_EVT_STAT: st_next.rdata = {29'h0, st_reg.evt_stat};
               cci_pkg::OFF_EVT_EN: st_next.rdata = {29'h0, st_reg.evt_en};
               default: st_next.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from state
   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.waitreq;
   assign core_irq = st_reg.core_irq;
   assign nmi_request = st_reg.nmi_req;
   assign nmi_redirect = st_reg.redirect;
   assign redirect_vector = st_reg.vector;
   assign irq_out = st_reg.irq_out;

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_bus_req_seen;
      clk_en && bus_req && avs_waitrequest;
   endsequence

   sequence s_bus_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_one_wait: assert property (s_bus_req_seen |=> s_bus_answer)
      else $error("bus answer not given after one wait cycle");

   a_nmi_latch_edge: assert property (
      clk_en && mco_rise |=> st_reg.nmi_lat == $past(st_reg.nmi_s2))
      else $error("non-maskable latch missed master clock edge");

   a_nmi_latch_hold: assert property (
      clk_en && !mco_rise |=> $stable(st_reg.nmi_lat))
      else $error("non-maskable latch moved without clock edge");

   a_nmi_req_invert: assert property (nmi_request == !st_reg.nmi_lat)
      else $error("non-maskable request not inverse of latch");

   a_nmi_vector_out: assert property (
      nmi_redirect |-> redirect_vector == cci_pkg::RESET_VECTOR)
      else $error("redirect not to reset vector");

   a_nmi_run_only: assert property (
      nmi_redirect |-> $past(pipeline_run) && $past(nmi_request))
      else $error("redirect while pipeline stalled");

   sequence s_nmi_ready;
      clk_en && nmi_request && pipeline_run && !st_reg.nmi_served;
   endsequence

   a_nmi_unmasked: assert property (s_nmi_ready |=> nmi_redirect)
      else $error("non-maskable request blocked");

   a_sw_pend_hold: assert property (
      !(clk_en && wr_go && avs_address == cci_pkg::OFF_CAUSE) |=> $stable(st_reg.sw_pend))
      else $error("software pending bits changed without write");

   a_hw_or_view: assert property (
      clk_en |=> st_reg.hw_pend == ($past(st_reg.int_reg) | $past(st_reg.line_s2)))
      else $error("hardware pending not OR of register and lines");

   // Reset count equals reset compare, so the edge still held in reset is left out
   a_timer_set: assert property (rst_b && clk_en && tmr_match |=> st_reg.tmr_pend)
      else $error("timer pending not set on compare match");

   a_timer_sticky: assert property (
      clk_en && st_reg.tmr_pend && !(wr_go && avs_address == cci_pkg::OFF_COMPARE)
      |=> st_reg.tmr_pend)
      else $error("timer pending dropped without compare write");

   a_core_irq_mask: assert property (
      clk_en |=> core_irq == ((|($past(pend_of(st_reg)) & $past(st_reg.mask)))
                              && $past(st_reg.ie) && !$past(st_reg.exception_level_bit)))
      else $error("core interrupt not masked product");

   a_core_irq_gate: assert property (
      clk_en && (!st_reg.ie || st_reg.exception_level_bit) |=> !core_irq)
      else $error("core interrupt raised while disabled");

   a_evt_irq_out: assert property (
      clk_en |=> irq_out == |($past(st_reg.evt_stat) & $past(st_reg.evt_en)))
      else $error("event interrupt does not follow enabled status");

   // Low clock enable leaves every state bit untouched
   a_freeze_hold: assert property (!clk_en |=> $stable(st_reg))
      else $error("state moved while clock enable low");

   // Sticky events drop only through the clear register
   a_evt_sticky: assert property (
      clk_en && !(wr_go && avs_address == cci_pkg::OFF_EVT_CLR)
      |=> (st_reg.evt_stat & $past(st_reg.evt_stat)) == $past(st_reg.evt_stat))
      else $error("sticky event bit lost without clear");

   // One pulse per request, so the pipeline is never sent twice
   a_redirect_once: assert property (clk_en && nmi_redirect |=> !nmi_redirect)
      else $error("redirect lasted more than one cycle");

   // Idle bus keeps waitrequest high so a new request always waits once
   a_wait_idle: assert property (clk_en && !bus_req && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped with no request");

   // Software bits take exactly what the write carries
   a_sw_write: assert property (
      clk_en && wr_go && avs_address == cci_pkg::OFF_CAUSE && avs_byteenable[1]
      |=> st_reg.sw_pend == $past(avs_writedata[cci_pkg::CA_SW_LSB +: 2]))
      else $error("software pending bits not written");

endmodule : cci_irq

// >>> hdl/cci_pkg.sv
// Constants for the core interrupt detection and masking block
package cci_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_CAUSE = 5'h04;
   localparam logic [4:0] OFF_INTREG = 5'h08;
   localparam logic [4:0] OFF_COUNT = 5'h0C;
   localparam logic [4:0] OFF_COMPARE = 5'h10;
   localparam logic [4:0] OFF_EVT_STAT = 5'h14;
   localparam logic [4:0] OFF_EVT_CLR = 5'h18;
   localparam logic [4:0] OFF_EVT_EN = 5'h1C;

   // Status register field positions
   localparam int ST_IE_POS = 0;
   localparam int ST_EXL_POS = 1;
   localparam int ST_MASK_LSB = 8;

   // Cause register field positions
   localparam int CA_PEND_LSB = 8;
   localparam int CA_SW_LSB = 8;
   localparam int CA_HW_LSB = 10;
   localparam int CA_TMR_POS = 15;

   // Event status bit positions
   localparam int EV_CORE_IRQ = 0;
   localparam int EV_NMI = 1;
   localparam int EV_TIMER = 2;
   localparam int EV_W = 3;

   // Values after reset
   localparam logic NMI_PIN_IDLE = 1'b1;
   localparam logic WAIT_IDLE = 1'b1;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [31:0] COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] COMPARE_RST = 32'h0000_0000;

   // Exception vector shared by reset and non-maskable request (arbitrary default)
   localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000;

endpackage : cci_pkg

// >>> tb/cci_irq_bench.sv
// Self-checking bench for the core interrupt block
`timescale 1ns/1ps
module cci_irq_bench;
   logic sys_clk, rst_b, clk_en, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address, hw_irq_lines, lines_cmd, ir;
   logic [31:0] avs_writedata, avs_readdata, redirect_vector, rd, st;
   logic [3:0] avs_byteenable;
   logic nmi_in_b, mclk, pipeline_run, core_irq, nmi_request, nmi_redirect, irq_out;
   logic run_cmd, nmi_cmd_b;
   logic [1:0] sw;
   int err_count, check_count, cyc, rcount, n;
   integer seed;
   cci_irq cci_irq_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .nmi_in_b(nmi_in_b), .core_master_clock_out(mclk), .hw_irq_lines(hw_irq_lines),
      .pipeline_run(pipeline_run), .core_irq(core_irq), .nmi_request(nmi_request),
      .nmi_redirect(nmi_redirect), .redirect_vector(redirect_vector), .irq_out(irq_out));
   cci_partner cci_partner_inst (.sys_clk(sys_clk), .rst_b(rst_b), .lines_cmd(lines_cmd),
      .run_cmd(run_cmd), .nmi_cmd_b(nmi_cmd_b), .nmi_redirect(nmi_redirect),
      .hw_irq_lines(hw_irq_lines), .pipeline_run(pipeline_run), .nmi_in_b(nmi_in_b),
      .core_master_clock_out(mclk), .redirect_count(rcount));
   // Clock, 4 ns period
   always #2 sys_clk = ~sys_clk;
   // Hang guard, far above the fewer than a thousand cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task wait_cyc(input int c);
      repeat (c) @(posedge sys_clk);
   endtask : wait_cyc
   // Request held until waitrequest seen low; one idle edge after release
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask : wr
   task rdr(input logic [4:0] a);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask : rdr
   // Expected core request from status and pending bits
   function automatic logic exp_irq(input logic [31:0] s, input logic [7:0] p);
      return s[0] & ~s[1] & (|(s[15:8] & p));
   endfunction : exp_irq
   task results;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   initial begin
      seed = 32'h813A;
      {sys_clk, rst_b, avs_read, avs_write, lines_cmd, run_cmd} = '0;
      {err_count, check_count, cyc} = '0;
      clk_en <= 1'b1;
      nmi_cmd_b <= 1'b1;
      avs_address <= 5'h00;
      avs_writedata <= 32'h0;
      avs_byteenable <= 4'hF;
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      check(32'(core_irq | nmi_request | irq_out), 32'h0);
      check(redirect_vector, 32'h0);
      @(posedge sys_clk);
      // Move compare away so the timer stays quiet; unmapped read
      wr(cci_pkg::OFF_COMPARE, 32'hFFFF_FFF0);
      rdr(5'h02);
      check(rd, 32'h0);
      // Software pending bits against masks, enable and level
      for (int i = 0; i < 10; i++) begin
         sw = 2'($random(seed));
         st = {16'h0, 8'($random(seed)), 6'h00, 2'($random(seed))};
         if (i == 0) st = 32'h0000_FF03;
         if (i == 1) begin
            st = 32'h0000_0101;
            sw = 2'h1;
         end
         wr(cci_pkg::OFF_CAUSE, {22'h0, sw, 8'h00});
         rdr(cci_pkg::OFF_CAUSE);
         check(rd[15:8], {6'h00, sw});
         wr(cci_pkg::OFF_STATUS, st);
         wait_cyc(3);
         check(32'(core_irq), 32'(exp_irq(st, {6'h00, sw})));
         wr(cci_pkg::OFF_CAUSE, 32'h0);
      end
      $display("software interrupt test done");
      // Hardware lines merged with the interrupt register
      for (int i = 0; i < 6; i++) begin
         ir = 5'($random(seed));
         lines_cmd <= 5'($random(seed)) & 5'h0F;
         st = {16'h0, 1'b0, 5'($random(seed)), 2'b00, 8'h01};
         wr(cci_pkg::OFF_INTREG, {27'h0, ir});
         wr(cci_pkg::OFF_STATUS, st);
         wait_cyc(8);
         rdr(cci_pkg::OFF_CAUSE);
         check(rd[14:10], ir | hw_irq_lines);
         check(32'(core_irq), 32'(exp_irq(st, {1'b0, ir | hw_irq_lines, 2'b00})));
      end
      lines_cmd <= 5'h00;
      wr(cci_pkg::OFF_INTREG, 32'h0);
      $display("hardware line test done");
      // Timer match sets and holds pending until compare is written
      wr(cci_pkg::OFF_STATUS, 32'h0000_8001);
      wr(cci_pkg::OFF_COMPARE, 32'h0000_0100);
      wr(cci_pkg::OFF_COUNT, 32'h0);
      wait_cyc(300);
      rdr(cci_pkg::OFF_CAUSE);
      check(32'(rd[15]), 32'h1);
      check(32'(core_irq), 32'h1);
      wr(cci_pkg::OFF_STATUS, 32'h0000_7F01);
      wait_cyc(2);
      check(32'(core_irq), 32'h0);
      wr(cci_pkg::OFF_COMPARE, 32'hFFFF_FFF0);
      rdr(cci_pkg::OFF_CAUSE);
      check(32'(rd[15]), 32'h0);
      // Sticky events, enable, clear; partial lane write
      rdr(cci_pkg::OFF_EVT_STAT);
      check(rd[2:0] & 3'h5, 3'h5);
      wr(cci_pkg::OFF_EVT_EN, 32'h4);
      wait_cyc(2);
      check(32'(irq_out), 32'h1);
      wr(cci_pkg::OFF_EVT_EN, 32'h0);
      wait_cyc(2);
      check(32'(irq_out), 32'h0);
      wr(cci_pkg::OFF_EVT_CLR, 32'h7);
      wr(cci_pkg::OFF_EVT_STAT, 32'h7);
      rdr(cci_pkg::OFF_EVT_STAT);
      check(rd, 32'h0);
      rdr(cci_pkg::OFF_EVT_CLR);
      check(rd, 32'h0);
      wr(cci_pkg::OFF_STATUS, 32'h0);
      bus(1'b1, cci_pkg::OFF_STATUS, 32'hFFFF_FFFF, 4'h1);
      rdr(cci_pkg::OFF_STATUS);
      check(rd, 32'h0000_0003);
      // Low clock enable freezes the count: only the three enabled edges after the read
      rdr(cci_pkg::OFF_COUNT);
      st = rd;
      clk_en <= 1'b0;
      wait_cyc(10);
      clk_en <= 1'b1;
      rdr(cci_pkg::OFF_COUNT);
      check(rd - st, 32'h3);
      $display("timer and event test done");
      // Non-maskable request with everything masked, pipeline stalled first
      nmi_cmd_b <= 1'b0;
      n = 0;
      while (nmi_request !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      check(32'(nmi_request), 32'h1);
      wait_cyc(20);
      check(rcount, 0);
      run_cmd <= 1'b1;
      wait_cyc(6);
      check(rcount, 1);
      check(redirect_vector, cci_pkg::RESET_VECTOR);
      rdr(cci_pkg::OFF_EVT_STAT);
      check(32'(rd[1]), 32'h1);
      nmi_cmd_b <= 1'b1;
      wait_cyc(40);
      check(32'(nmi_request), 32'h0);
      $display("non-maskable test done");
      results();
   end
endmodule : cci_irq_bench

// >>> tb/cci_partner.sv
// Partner model: interrupt sources and pipeline run state
`timescale 1ns/1ps
module cci_partner (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Bench commands
   input wire logic [4:0] lines_cmd,
   input wire logic run_cmd,
   input wire logic nmi_cmd_b,
   // Design side
   input wire logic nmi_redirect,
   output logic [4:0] hw_irq_lines,
   output logic pipeline_run,
   output logic nmi_in_b,
   output logic core_master_clock_out,
   output int redirect_count
);
   logic [2:0] div_reg;
   // Sources follow bench commands one edge late; master clock runs free
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= 3'h0;
         hw_irq_lines <= 5'h00;
         pipeline_run <= 1'b0;
         nmi_in_b <= 1'b1;
         redirect_count <= 0;
      end else begin
         div_reg <= div_reg + 3'h1;
         hw_irq_lines <= {1'b0, lines_cmd[3:0]}; // Top line never rises
         pipeline_run <= run_cmd;
         nmi_in_b <= nmi_cmd_b;
         if (nmi_redirect) redirect_count <= redirect_count + 1;
      end
   end
   // Divide by 8 so the latch edge is well apart from sys_clk
   assign core_master_clock_out = div_reg[2];
endmodule : cci_partner
